// File: flash_ctrl_pkg.sv
// Constants, opcodes and state encoding for the erase and power-down sequencer
package flash_ctrl_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int PUW_LOCKOUT_US   = 1000;
	localparam int PUW_LOCKOUT_CYC  = PUW_LOCKOUT_US * CLK_MHZ;
	localparam int PAGE_ERASE_CYC   = 2000;
	localparam int SECTOR_ERASE_CYC = 4000;
	localparam int SLEEP_ENTRY_CYC  = 750;
	localparam int WAKE_CYC         = 750;
	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	localparam logic [5:0] OPC_BITS    = 6'h08;
	localparam logic [5:0] ADDR_BITS   = 6'h20;
	localparam logic [5:0] BITS_SAT    = 6'h3F;
	localparam logic [3:0] PROT_SECTOR = 4'h0;
	localparam int         SECT_MSB    = 19;
	localparam int         SECT_LSB    = 16;
	localparam int         PAGE_LSB    = 8;
	localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OPC_PAGE_ERASE   = 8'hDB;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'hD8;
	localparam logic [7:0] OPC_DEEP_SLEEP   = 8'hB9;
	localparam logic [7:0] OPC_WAKE         = 8'hAB;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ERASE = 3'b001,
		ST_ENTER = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE  = 3'b100
	} state_t;
endpackage : flash_ctrl_pkg

// File: delay_timer_if.sv
// Handshake between the sequencer and its delay timer
`timescale 1ns/100ps
interface delay_timer_if;
	logic        start;
	logic [31:0] load;
	logic        done;
	logic        run;
	modport ctrl  (output start, output load, input done, input run);
	modport timer (input start, input load, output done, output run);
endinterface : delay_timer_if

// File: delay_timer.sv
// Down-counter timebase for the self-timed delays
`timescale 1ns/100ps
module delay_timer (
	input  wire logic     i_clk,
	input  wire logic     i_rst,
	input  wire logic     i_ce,
	delay_timer_if.timer  t
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic        done;
	logic        next_done;

	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (t.start) begin
			next_cnt = t.load;
		end else if (cnt != 32'h0) begin
			next_cnt = cnt - 32'h1;
			next_done = (cnt == 32'h1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt  <= 32'h0;
			done <= 1'b0;
		end else if (i_ce) begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

	assign t.done = done;
	assign t.run  = (cnt != 32'h0);
endmodule : delay_timer

// File: flash_erase_seq.sv
// Serial flash erase, deep sleep and power-up lockout sequencer
`timescale 1ns/100ps
// Summary of operation
// - Erase commands accepted only with write_enable_latch set by write_unlock_cmd.
// - Page erase drives whole page to all ones.
// - Page erase is opcode plus three address bytes; any byte selects page.
// - Address bits 23 to 20 are ignored.
// - Erase runs only if select rises right after bit 32.
// - Select rise starts self-timed erase; busy_flag high until done.
// - write_enable_latch cleared before the erase ends.
// - Page erase in protected region is not executed.
// - Sector erase clears sector holding the supplied address.
// - Sector erase of a sector with protected pages is not executed.
// - Commands during a running cycle rejected, cycle undisturbed.
// - Deep sleep ignores all write and erase commands.
// - Select high with no cycle running means standby, not deep sleep.
// - deep_sleep_cmd is opcode only, runs if select rises after bit 8.
// - sleep_entry_delay elapses before deep sleep is entered.
// - Device always comes up in standby, never deep sleep.
// - Extra clocks on wake_from_sleep_cmd reject it.
// - Standby follows wake_delay; host keeps select high meanwhile.
// - Write and erase commands ignored during powerup_write_lockout.
// - Latch and busy flag start cleared.
module flash_erase_seq #(
	parameter int PAGE_ERASE_CYC   = flash_ctrl_pkg::PAGE_ERASE_CYC,
	parameter int SECTOR_ERASE_CYC = flash_ctrl_pkg::SECTOR_ERASE_CYC,
	parameter int SLEEP_ENTRY_CYC  = flash_ctrl_pkg::SLEEP_ENTRY_CYC,
	parameter int WAKE_CYC         = flash_ctrl_pkg::WAKE_CYC,
	parameter int LOCKOUT_CYC      = flash_ctrl_pkg::PUW_LOCKOUT_CYC
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic        I_CS_N,
	input  wire logic        I_SCK,
	input  wire logic        I_MOSI,
	input  wire logic        I_WP_N,
	output logic             O_BUSY,
	output logic             O_WEL,
	output logic             O_STANDBY,
	output logic             O_DEEP_SLEEP,
	output logic             O_LOCKOUT,
	output logic             O_ERASE_STB,
	output logic             O_ERASE_SECTOR,
	output logic [19:0]      O_ERASE_ADDR
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_erase(input logic [7:0] op);
		return (op == flash_ctrl_pkg::OPC_PAGE_ERASE) ||
			(op == flash_ctrl_pkg::OPC_SECTOR_ERASE);
	endfunction : is_erase

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic cs_m, cs_s, cs_d;
	logic sck_m, sck_s, sck_d;
	logic mosi_m, mosi_s;
	logic wp_m, wp_s;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cs_m   <= 1'b1;
			cs_s   <= 1'b1;
			cs_d   <= 1'b1;
			sck_m  <= 1'b0;
			sck_s  <= 1'b0;
			sck_d  <= 1'b0;
			mosi_m <= 1'b0;
			mosi_s <= 1'b0;
			wp_m   <= 1'b1;
			wp_s   <= 1'b1;
		end else if (I_CE) begin
			cs_m   <= I_CS_N;
			cs_s   <= cs_m;
			cs_d   <= cs_s;
			sck_m  <= I_SCK;
			sck_s  <= sck_m;
			sck_d  <= sck_s;
			mosi_m <= I_MOSI;
			mosi_s <= mosi_m;
			wp_m   <= I_WP_N;
			wp_s   <= wp_m;
		end
	end

	logic cs_rise;
	logic sck_rise;
	assign cs_rise  = cs_s & ~cs_d;
	assign sck_rise = sck_s & ~sck_d & ~cs_s;

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [31:0] shreg, next_shreg;
	logic [5:0]  bit_cnt, next_bit_cnt;

	always_comb begin
		next_shreg   = shreg;
		next_bit_cnt = bit_cnt;
		if (cs_s) begin
			next_bit_cnt = 6'h00;
		end else if (sck_rise) begin
			next_shreg = {shreg[30:0], mosi_s};
			// Saturate so stray clocks never wrap back to a legal count
			if (bit_cnt != flash_ctrl_pkg::BITS_SAT)
				next_bit_cnt = bit_cnt + 6'h01;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			shreg   <= 32'h0;
			bit_cnt <= 6'h00;
		end else if (I_CE) begin
			shreg   <= next_shreg;
			bit_cnt <= next_bit_cnt;
		end
	end

	// ----------------------------------------
	// Frame decode at select release
	// ----------------------------------------
	logic        len8, len32, protected_hit, lockout;
	logic [7:0]  opc8, opc32;
	logic        do_unlock, do_erase, do_sleep, do_wake;
	flash_ctrl_pkg::state_t state, next_state;
	logic        write_enable_latch;

	assign len8  = (bit_cnt == flash_ctrl_pkg::OPC_BITS);
	assign len32 = (bit_cnt == flash_ctrl_pkg::ADDR_BITS);
	assign opc8  = shreg[7:0];
	assign opc32 = shreg[31:24];
	// Bottom sector guard also covers every page inside it
	assign protected_hit = ~wp_s &&
		(shreg[flash_ctrl_pkg::SECT_MSB:flash_ctrl_pkg::SECT_LSB] ==
		flash_ctrl_pkg::PROT_SECTOR);

	assign do_unlock = cs_rise && len8 && state == flash_ctrl_pkg::ST_IDLE &&
		opc8 == flash_ctrl_pkg::OPC_WRITE_UNLOCK && !lockout;
	assign do_erase = cs_rise && len32 && is_erase(opc32) && write_enable_latch && !lockout &&
		state == flash_ctrl_pkg::ST_IDLE && !protected_hit;
	assign do_sleep = cs_rise && len8 && opc8 == flash_ctrl_pkg::OPC_DEEP_SLEEP &&
		state == flash_ctrl_pkg::ST_IDLE;
	assign do_wake = cs_rise && len8 && opc8 == flash_ctrl_pkg::OPC_WAKE &&
		state == flash_ctrl_pkg::ST_SLEEP;

	// ----------------------------------------
	// Delay timer
	// ----------------------------------------
	delay_timer_if tmr ();

	delay_timer u_timer (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_ce  (I_CE),
		.t     (tmr.timer)
	);

	always_comb begin
		tmr.start = do_erase | do_sleep | do_wake;
		tmr.load  = 32'(WAKE_CYC);
		if (do_erase)
			tmr.load = (opc32 == flash_ctrl_pkg::OPC_SECTOR_ERASE) ?
				32'(SECTOR_ERASE_CYC) : 32'(PAGE_ERASE_CYC);
		else if (do_sleep)
			tmr.load = 32'(SLEEP_ENTRY_CYC);
	end

	// ----------------------------------------
	// Power-up lockout
	// ----------------------------------------
	logic [31:0] lock_cnt, next_lock_cnt;

	assign lockout = (lock_cnt != 32'h0);

	always_comb begin
		next_lock_cnt = lock_cnt;
		if (lockout)
			next_lock_cnt = lock_cnt - 32'h1;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			lock_cnt  <= 32'(LOCKOUT_CYC);
			O_LOCKOUT <= 1'b1;
		end else if (I_CE) begin
			lock_cnt  <= next_lock_cnt;
			O_LOCKOUT <= (next_lock_cnt != 32'h0);
		end
	end

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	logic        next_wel;
	logic        next_stb, next_sector;
	logic [19:0] next_addr;

	always_comb begin
		next_state  = state;
		next_wel    = write_enable_latch;
		next_stb    = 1'b0;
		next_sector = O_ERASE_SECTOR;
		next_addr   = O_ERASE_ADDR;
		if (do_unlock)
			next_wel = 1'b1;
		case (state)
			flash_ctrl_pkg::ST_IDLE: begin
				if (do_erase) begin
					next_state  = flash_ctrl_pkg::ST_ERASE;
					next_wel    = 1'b0;
					next_stb    = 1'b1;
					next_sector = (opc32 == flash_ctrl_pkg::OPC_SECTOR_ERASE);
					// Top nibble dropped; low byte kept, page selected above it
					next_addr   = shreg[19:0];
				end else if (do_sleep) begin
					next_state = flash_ctrl_pkg::ST_ENTER;
				end
			end
			flash_ctrl_pkg::ST_ERASE: begin
				// Select activity is ignored until the timer ends
				if (tmr.done)
					next_state = flash_ctrl_pkg::ST_IDLE;
			end
			flash_ctrl_pkg::ST_ENTER: begin
				if (tmr.done)
					next_state = flash_ctrl_pkg::ST_SLEEP;
			end
			flash_ctrl_pkg::ST_SLEEP: begin
				if (do_wake)
					next_state = flash_ctrl_pkg::ST_WAKE;
			end
			flash_ctrl_pkg::ST_WAKE: begin
				if (tmr.done)
					next_state = flash_ctrl_pkg::ST_IDLE;
			end
			default: next_state = flash_ctrl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			state          <= flash_ctrl_pkg::ST_IDLE;
			write_enable_latch            <= 1'b0;
			O_WEL          <= 1'b0;
			O_BUSY         <= 1'b0;
			O_STANDBY      <= 1'b1;
			O_DEEP_SLEEP   <= 1'b0;
			O_ERASE_STB    <= 1'b0;
			O_ERASE_SECTOR <= 1'b0;
			O_ERASE_ADDR   <= 20'h00000;
		end else if (I_CE) begin
			state          <= next_state;
			write_enable_latch            <= next_wel;
			O_WEL          <= next_wel;
			O_BUSY         <= (next_state == flash_ctrl_pkg::ST_ERASE);
			O_STANDBY      <= (next_state == flash_ctrl_pkg::ST_IDLE) && cs_s;
			O_DEEP_SLEEP   <= (next_state == flash_ctrl_pkg::ST_SLEEP);
			O_ERASE_STB    <= next_stb;
			O_ERASE_SECTOR <= next_sector;
			O_ERASE_ADDR   <= next_addr;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_erase_start;
		I_CE && do_erase;
	endsequence

	sequence s_erase_seen;
		O_ERASE_STB && O_BUSY && !O_WEL;
	endsequence

	property p_wel_needed;
		s_erase_start |-> write_enable_latch && !lockout;
	endproperty
	a_wel_needed: assert property (p_wel_needed) else $error("erase without latch");

	property p_erase_issue;
		s_erase_start |=> s_erase_seen;
	endproperty
	a_erase_issue: assert property (p_erase_issue) else $error("erase not issued");

	property p_exact_len;
		s_erase_start |-> bit_cnt == 6'h20 && cs_rise;
	endproperty
	a_exact_len: assert property (p_exact_len) else $error("erase on bad length");

	property p_addr_kept;
		s_erase_start |=> O_ERASE_ADDR == $past(shreg[19:0]);
	endproperty
	a_addr_kept: assert property (p_addr_kept) else $error("erase address wrong");

	property p_busy_end;
		$fell(O_BUSY) |-> $past(tmr.done);
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy ended early");

	property p_wel_clear;
		O_BUSY |-> !O_WEL;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch set while busy");

	property p_protect;
		s_erase_start |-> !(!wp_s && shreg[19:16] == 4'h0);
	endproperty
	a_protect: assert property (p_protect) else $error("protected erase");

	property p_busy_hold;
		O_BUSY && I_CE && !tmr.done |=> O_BUSY && $stable(O_ERASE_ADDR);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("cycle disturbed");

	property p_sleep_quiet;
		state == flash_ctrl_pkg::ST_SLEEP |=> (!O_BUSY && !O_ERASE_STB && !O_WEL) [*2];
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("write in sleep");

	property p_sleep_entry;
		I_CE && do_sleep |=> state == flash_ctrl_pkg::ST_ENTER && !O_DEEP_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered early");

	property p_lockout;
		O_LOCKOUT && I_CE |=> !O_BUSY && !$rose(O_WEL);
	endproperty
	a_lockout: assert property (p_lockout) else $error("write during lockout");
endmodule : flash_erase_seq

// File: spi_host_model.sv
// Host side serial master model: select, serial clock and data in
`timescale 1ns/100ps
module spi_host_model (
	input  wire logic i_clk,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_mosi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_mosi = 1'b0;
	end
	// ----------------------------------------
	// Frame
	// ----------------------------------------
	// MSB first, 48 ns bit time, clock still outside frames
	task automatic send(input logic [39:0] d, input int n);
		@(negedge i_clk);
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_mosi = d[i];
			repeat (6) @(negedge i_clk);
			o_sck = 1'b1;
			repeat (6) @(negedge i_clk);
			o_sck = 1'b0;
		end
		repeat (6) @(negedge i_clk);
		o_cs_n = 1'b1;
		// Released line must not keep a stale bit
		o_mosi = ~o_mosi;
		repeat (8) @(negedge i_clk);
	endtask : send
endmodule : spi_host_model

// File: serial_flash_erase_powerdown_ctrl_tb.sv
// Self-checking bench for the erase and deep sleep sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module serial_flash_erase_powerdown_ctrl_tb;
	localparam int PG = 200;
	localparam int SC = 400;
	localparam int SL = 100;
	localparam int WK = 100;
	localparam int LK = 300;
	// Stand-in for the supply settling time before first select
	localparam int VSL = 8;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        wp_n = 1'b1;
	logic        cs_n;
	logic        sck;
	logic        mosi;
	logic        busy;
	logic        write_enable_latch;
	logic        standby;
	logic        sleep;
	logic        lockout;
	logic        stb;
	logic        sector;
	logic [19:0] addr;
	int          fails = 0;
	int          num_checks = 0;
	int          stbs = 0;
	int          blen = 0;

	always #2 clk = ~clk;

	spi_host_model host_u (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

	flash_erase_seq #(.PAGE_ERASE_CYC(PG), .SECTOR_ERASE_CYC(SC), .SLEEP_ENTRY_CYC(SL),
		.WAKE_CYC(WK), .LOCKOUT_CYC(LK)) dut_u (
		.I_CLK          (clk),
		.I_RST          (rst),
		.I_CE           (ce),
		.I_CS_N         (cs_n),
		.I_SCK          (sck),
		.I_MOSI         (mosi),
		.I_WP_N         (wp_n),
		.O_BUSY         (busy),
		.O_WEL          (write_enable_latch),
		.O_STANDBY      (standby),
		.O_DEEP_SLEEP   (sleep),
		.O_LOCKOUT      (lockout),
		.O_ERASE_STB    (stb),
		.O_ERASE_SECTOR (sector),
		.O_ERASE_ADDR   (addr)
	);

	// Sampled on the falling edge, where the registered outputs have settled
	always @(negedge clk) begin
		if (stb === 1'b1) begin
			stbs <= stbs + 1;
			blen <= 1;
		end else if (busy === 1'b1) begin
			blen <= blen + 1;
		end
	end

	task automatic wait_idle;
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
	endtask : wait_idle

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		`CHK(busy, 1'b0)
		`CHK(write_enable_latch, 1'b0)
		`CHK(standby, 1'b1)
		`CHK(sleep, 1'b0)
		`CHK(lockout, 1'b1)
		repeat (VSL) @(negedge clk);
		host_u.send(40'h06, 8);
		`CHK(write_enable_latch, 1'b0)
		`CHK(lockout, 1'b1)
		for (int i = 0; i < LK && lockout !== 1'b0; i++) @(negedge clk);
		`CHK(lockout, 1'b0)
		host_u.send({8'hDB, 24'h012345}, 32);
		`CHK(stbs, 0)
		host_u.send(40'h06, 8);
		`CHK(write_enable_latch, 1'b1)
		host_u.send({8'hDB, 24'h012345, 1'b0}, 33);
		`CHK(stbs, 0)
		`CHK(write_enable_latch, 1'b1)
		host_u.send({8'hDB, 24'hF12345}, 32);
		`CHK(stbs, 1)
		`CHK(sector, 1'b0)
		`CHK(addr, 20'h12345)
		`CHK(busy, 1'b1)
		`CHK(write_enable_latch, 1'b0)
		host_u.send(40'hB9, 8);
		`CHK(busy, 1'b1)
		wait_idle;
		// Busy spans the count plus the cycle in which the timer reports done
		`CHK(blen, PG + 1)
		`CHK(sleep, 1'b0)
		`CHK(standby, 1'b1)
		wp_n = 1'b0;
		host_u.send(40'h06, 8);
		host_u.send({8'hD8, 24'h00ABCD}, 32);
		`CHK(stbs, 1)
		host_u.send({8'hDB, 24'hF00100}, 32);
		`CHK(stbs, 1)
		host_u.send({8'hD8, 24'hA35678}, 32);
		`CHK(stbs, 2)
		`CHK(sector, 1'b1)
		`CHK(addr, 20'h35678)
		wait_idle;
		`CHK(blen, SC + 1)
		host_u.send(40'h172, 9);
		repeat (SL + 20) @(negedge clk);
		`CHK(sleep, 1'b0)
		host_u.send(40'hB9, 8);
		`CHK(sleep, 1'b0)
		repeat (SL) @(negedge clk);
		`CHK(sleep, 1'b1)
		`CHK(standby, 1'b0)
		// Deliberate stray write while asleep, to probe that it is ignored
		host_u.send(40'h06, 8);
		`CHK(write_enable_latch, 1'b0)
		host_u.send(40'h156, 9);
		`CHK(sleep, 1'b1)
		host_u.send(40'hAB, 8);
		`CHK(sleep, 1'b0)
		`CHK(standby, 1'b0)
		repeat (WK) @(negedge clk);
		`CHK(standby, 1'b1)
		host_u.send(40'hB9, 8);
		// Frozen clock enable must stall the entry delay
		ce = 1'b0;
		repeat (SL + 20) @(negedge clk);
		`CHK(sleep, 1'b0)
		ce = 1'b1;
		repeat (SL + 8) @(negedge clk);
		`CHK(sleep, 1'b1)
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		`CHK(sleep, 1'b0)
		`CHK(standby, 1'b1)
		`CHK(lockout, 1'b1)
		wrap_up;
	end
endmodule : serial_flash_erase_powerdown_ctrl_tb
